// file: common/dma_controller_pkg.sv
// Register map, field layout and state encoding of the channel 0 mode control
package dma_controller_pkg;
	// Word indices; the byte address is four times the index
	localparam logic [5:0] IDX_SRC = 6'h20;
	localparam logic [5:0] IDX_DST = 6'h21;
	localparam logic [5:0] IDX_CNT = 6'h22;
	localparam logic [5:0] IDX_EN = 6'h30;
	localparam logic [5:0] IDX_MODE = 6'h31;
	localparam logic [5:0] IDX_DMA_WAIT_CTRL_REG = 6'h32;
	// channel0_mode_reg fields
	localparam int MD_DST_HI = 5;
	localparam int MD_DST_LO = 4;
	localparam int MD_SRC_HI = 3;
	localparam int MD_SRC_LO = 2;
	localparam int MD_TIM = 1;
	localparam logic [7:0] MODE_MASK = 8'h3e;
	localparam logic [7:0] MODE_RST = 8'h00;
	// dma_wait_ctrl_reg fields
	localparam int DC_MWI_HI = 7;
	localparam int DC_MWI_LO = 6;
	localparam int DC_IWI_HI = 5;
	localparam int DC_IWI_LO = 4;
	localparam int DC_DMS1 = 3;
	localparam int DC_DMS0 = 2;
	localparam int DC_DIM_HI = 1;
	localparam int DC_DIM_LO = 0;
	localparam logic [7:0] DMA_WAIT_CTRL_REG_RST = 8'hf0;
	// Enable register fields
	localparam int EN_DE0 = 6;
	localparam int EN_DWE1 = 5;
	localparam int EN_DWE0 = 4;
	localparam int EN_DME = 0;
	// Source and destination kinds
	localparam logic [1:0] KIND_INC = 2'h0;
	localparam logic [1:0] KIND_DEC = 2'h1;
	localparam logic [1:0] KIND_FIX = 2'h2;
	localparam logic [1:0] KIND_IO = 2'h3;
	localparam int AW = 20;
	localparam int CW = 16;
	typedef enum logic [1:0] {
		RD_IDLE = 2'h0,
		RD_READ = 2'h1,
		RD_DRAIN = 2'h3,
		RD_STEAL = 2'h2
	} rd_state_t;
endpackage

// file: design/dma_ch0_ctrl.sv
// Channel 0 transfer-mode control: registers, pacing, wait states, byte mover
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/10ps
module dma_ch0_ctrl
	import dma_controller_pkg::*;
(
	input wire logic clock, // 25 MHz system clock
	input wire logic rst_n, // Async reset, active low
	input wire logic [7:0] address, // Avalon byte address
	input wire logic read, // Avalon read
	input wire logic write, // Avalon write
	input wire logic [31:0] writedata, // Avalon write data
	input wire logic [3:0] byteenable, // Avalon byte lanes
	output logic [31:0] readdata, // Avalon read data
	output logic waitrequest, // Avalon wait
	input wire logic request_in_0, // Channel 0 request pin
	input wire logic request_in_1, // Channel 1 request pin
	input wire logic nmi, // Non-maskable interrupt pin
	input wire logic cpu_cycle_start, // CPU access begins
	input wire logic cpu_cycle_io, // That CPU access is I/O
	output logic cpu_wait, // Stretch the CPU access
	output logic bus_own, // DMA owns the system bus
	output logic rd_strobe, // Source access active
	output logic [19:0] rd_addr, // Source address
	output logic rd_io, // Source is I/O space
	input wire logic [7:0] rd_data, // Source byte
	output logic wr_strobe, // Destination access active
	output logic [19:0] wr_addr, // Destination address
	output logic wr_io, // Destination is I/O space
	output logic [7:0] wr_data, // Destination byte
	input wire logic wr_ready, // Destination can accept
	output logic ch1_request, // Channel 1 request seen
	output logic ch1_mem_to_io // Channel 1 direction
);
	logic [31:0] readdata_r;
	logic waitrequest_r;
	logic [7:0] mode_r, dma_wait_ctrl_reg_r;
	logic [AW-1:0] src_r, dst_r, src_nxt, dst_nxt;
	logic [CW-1:0] cnt_r, cnt_nxt;
	logic de0_r, de0_nxt, dme_r, dme_nxt;
	rd_state_t st_r, st_nxt;
	logic [1:0] rcnt_r, wcnt_r, ccnt_r, ccnt_nxt;
	logic wr_busy_r, wr_busy_nxt;
	logic [7:0] buf_q [2];
	logic [1:0] occ_r;
	logic req0_q1, req0_q2, req0_q3, req0_pend_r;
	logic req1_q1, req1_q2, req1_q3;
	logic nmi_q1, nmi_q2, nmi_q3;
	logic cpu_wait_r, bus_own_r, rd_strobe_r, rd_io_r, wr_strobe_r, wr_io_r;
	logic [AW-1:0] rd_addr_r, wr_addr_r;
	logic [7:0] wr_data_r;
	logic ch1_request_r, ch1_mem_to_io_r;
	logic [7:0] en_rd;

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] w,
		input logic [3:0] be);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = w[8*i +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [AW-1:0] step(input logic [AW-1:0] a, input logic [1:0] k);
		logic [AW-1:0] r;
		r = a;
		if (k == KIND_INC) begin
			r = a + 20'h1;
		end else if (k == KIND_DEC) begin
			r = a - 20'h1;
		end
		return r;
	endfunction

	// Register decode
	wire [5:0] idx = address[7:2];
	wire bus_wr = write & ~waitrequest_r;
	wire sel_src = idx == IDX_SRC;
	wire sel_dst = idx == IDX_DST;
	wire sel_cnt = idx == IDX_CNT;
	wire sel_en = idx == IDX_EN;
	wire sel_mode = idx == IDX_MODE;
	wire sel_dma_wait_ctrl_reg = idx == IDX_DMA_WAIT_CTRL_REG;
	wire ack_nxt = (read | write) & waitrequest_r;

	// Mode decode
	wire [1:0] dkind = mode_r[MD_DST_HI:MD_DST_LO];
	wire [1:0] skind = mode_r[MD_SRC_HI:MD_SRC_LO];
	wire mode_bad = dkind[1] & skind[1];
	wire io_mode = (dkind == KIND_IO) | (skind == KIND_IO);
	wire burst = ~io_mode & mode_r[MD_TIM];
	wire cyc_steal = ~io_mode & ~mode_r[MD_TIM];
	wire run = de0_r & dme_r;
	wire [1:0] mwi = dma_wait_ctrl_reg_r[DC_MWI_HI:DC_MWI_LO];
	wire [1:0] iwi = dma_wait_ctrl_reg_r[DC_IWI_HI:DC_IWI_LO];
	wire [1:0] rd_wait = (skind == KIND_IO) ? iwi : mwi;
	wire [1:0] wr_wait = (dkind == KIND_IO) ? iwi : mwi;

	// Request sense
	wire req0_edge = req0_q2 & ~req0_q3;
	wire req1_edge = req1_q2 & ~req1_q3;
	wire nmi_edge = nmi_q2 & ~nmi_q3;
	wire req0_ok = dma_wait_ctrl_reg_r[DC_DMS0] ? req0_pend_r : req0_q2;
	wire pace_ok = io_mode ? req0_ok : 1'b1;

	// Two-entry buffer between source reads and destination writes
	wire buf_in_ready = occ_r != 2'h2;
	wire buf_out_valid = occ_r != 2'h0;
	wire buf_out_ready = ~wr_busy_r & wr_ready;
	wire [1:0] pending = occ_r + {1'b0, wr_busy_r};
	// Reads run ahead of writes only as far as the count allows
	wire more = cnt_r > CW'(pending);
	wire rd_start = (st_r == RD_IDLE) & run & ~mode_bad & more & pace_ok & buf_in_ready;
	wire rd_done = (st_r == RD_READ) & (rcnt_r == 2'h0);
	wire buf_in_valid = rd_done;
	wire wr_start = buf_out_valid & buf_out_ready;
	wire wr_done = wr_busy_r & (wcnt_r == 2'h0);
	wire sw_de0 = bus_wr & sel_en & byteenable[0] & ~writedata[EN_DWE0];
	wire last_byte = wr_done & (cnt_r == CW'(1));

	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			RD_IDLE: begin
				if (rd_start) begin
					st_nxt = RD_READ;
				end
			end
			RD_READ: begin
				if (rd_done) begin
					st_nxt = cyc_steal ? RD_DRAIN : RD_IDLE;
				end
			end
			RD_DRAIN: begin
				if (occ_r == 2'h0 && !wr_busy_r) begin
					st_nxt = RD_STEAL;
				end
			end
			RD_STEAL: begin
				st_nxt = RD_IDLE;
			end
		endcase
	end

	assign wr_busy_nxt = wr_start | (wr_busy_r & ~wr_done);
	// Burst holds the bus between bytes; a stolen cycle always releases it
	wire burst_hold = burst & run & ~mode_bad & (cnt_r != '0);
	wire own_nxt = (st_nxt != RD_STEAL)
		& ((st_nxt == RD_READ) | (st_nxt == RD_DRAIN) | wr_busy_nxt | burst_hold);

	// Software writes win over the byte mover in the same cycle
	assign src_nxt = (bus_wr && sel_src) ? AW'(merge(32'(src_r), writedata, byteenable))
		: rd_done ? step(src_r, skind) : src_r;
	assign dst_nxt = (bus_wr && sel_dst) ? AW'(merge(32'(dst_r), writedata, byteenable))
		: wr_done ? step(dst_r, dkind) : dst_r;
	assign cnt_nxt = (bus_wr && sel_cnt) ? CW'(merge(32'(cnt_r), writedata, byteenable))
		: wr_done ? cnt_r - CW'(1) : cnt_r;
	// A software set of the enable wins over the terminal-count clear
	assign de0_nxt = sw_de0 ? writedata[EN_DE0] : (de0_r & ~last_byte);
	assign dme_nxt = (sw_de0 & writedata[EN_DE0]) | (dme_r & ~nmi_edge);
	assign ccnt_nxt = cpu_cycle_start ? (cpu_cycle_io ? iwi : mwi)
		: (ccnt_r != 2'h0) ? ccnt_r - 2'h1 : 2'h0;

	always_comb begin
		en_rd = 8'h00;
		en_rd[EN_DE0] = de0_r;
		en_rd[EN_DWE1] = 1'b1;
		en_rd[EN_DWE0] = 1'b1;
		en_rd[EN_DME] = dme_r;
	end

	wire [31:0] rd_mux = sel_src ? 32'(src_r) : sel_dst ? 32'(dst_r)
		: sel_cnt ? 32'(cnt_r) : sel_en ? 32'(en_rd)
		: sel_mode ? 32'(mode_r & MODE_MASK) : sel_dma_wait_ctrl_reg ? 32'(dma_wait_ctrl_reg_r) : 32'h0;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			waitrequest_r <= 1'b1;
			readdata_r <= 32'h0;
		end else begin
			waitrequest_r <= ~ack_nxt;
			readdata_r <= (ack_nxt & read) ? rd_mux : 32'h0;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mode_r <= MODE_RST;
			dma_wait_ctrl_reg_r <= DMA_WAIT_CTRL_REG_RST;
		end else if (bus_wr && byteenable[0]) begin
			if (sel_mode) begin
				mode_r <= writedata[7:0] & MODE_MASK;
			end
			if (sel_dma_wait_ctrl_reg) begin
				dma_wait_ctrl_reg_r <= writedata[7:0];
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			src_r <= '0;
			dst_r <= '0;
			cnt_r <= '0;
			de0_r <= 1'b0;
			dme_r <= 1'b0;
		end else begin
			src_r <= src_nxt;
			dst_r <= dst_nxt;
			cnt_r <= cnt_nxt;
			de0_r <= de0_nxt;
			dme_r <= dme_nxt;
		end
	end

	// Pins from outside pass two flops before edge detection
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			{req0_q1, req0_q2, req0_q3} <= 3'h0;
			{req1_q1, req1_q2, req1_q3} <= 3'h0;
			{nmi_q1, nmi_q2, nmi_q3} <= 3'h0;
			req0_pend_r <= 1'b0;
		end else begin
			{req0_q1, req0_q2, req0_q3} <= {request_in_0, req0_q1, req0_q2};
			{req1_q1, req1_q2, req1_q3} <= {request_in_1, req1_q1, req1_q2};
			{nmi_q1, nmi_q2, nmi_q3} <= {nmi, nmi_q1, nmi_q2};
			req0_pend_r <= req0_edge | (req0_pend_r & ~rd_start);
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= RD_IDLE;
			rcnt_r <= 2'h0;
			rd_strobe_r <= 1'b0;
			rd_addr_r <= '0;
			rd_io_r <= 1'b0;
			bus_own_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			rd_strobe_r <= st_nxt == RD_READ;
			bus_own_r <= own_nxt;
			if (rd_start) begin
				rcnt_r <= rd_wait;
				rd_addr_r <= src_r;
				rd_io_r <= skind == KIND_IO;
			end else if (rcnt_r != 2'h0) begin
				rcnt_r <= rcnt_r - 2'h1;
			end
		end
	end

	// Buffer storage: entry 0 is always the oldest byte
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			occ_r <= 2'h0;
			buf_q[0] <= 8'h00;
			buf_q[1] <= 8'h00;
		end else begin
			occ_r <= occ_r + {1'b0, buf_in_valid} - {1'b0, wr_start};
			if (wr_start) begin
				buf_q[0] <= (buf_in_valid && occ_r == 2'h1) ? rd_data : buf_q[1];
				if (buf_in_valid && occ_r == 2'h2) begin
					buf_q[1] <= rd_data;
				end
			end else if (buf_in_valid) begin
				buf_q[occ_r[0]] <= rd_data;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wr_busy_r <= 1'b0;
			wcnt_r <= 2'h0;
			wr_strobe_r <= 1'b0;
			wr_addr_r <= '0;
			wr_io_r <= 1'b0;
			wr_data_r <= 8'h00;
		end else begin
			wr_busy_r <= wr_busy_nxt;
			wr_strobe_r <= wr_busy_nxt;
			if (wr_start) begin
				wcnt_r <= wr_wait;
				wr_addr_r <= dst_r;
				wr_io_r <= dkind == KIND_IO;
				wr_data_r <= buf_q[0];
			end else if (wcnt_r != 2'h0) begin
				wcnt_r <= wcnt_r - 2'h1;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ccnt_r <= 2'h0;
			cpu_wait_r <= 1'b0;
			ch1_request_r <= 1'b0;
			ch1_mem_to_io_r <= 1'b1;
		end else begin
			ccnt_r <= ccnt_nxt;
			cpu_wait_r <= ccnt_nxt != 2'h0;
			ch1_request_r <= dma_wait_ctrl_reg_r[DC_DMS1] ? req1_edge : req1_q2;
			// Channel 1 has no memory-to-memory code at all
			ch1_mem_to_io_r <= ~dma_wait_ctrl_reg_r[DC_DIM_HI];
		end
	end

	assign readdata = readdata_r;
	assign waitrequest = waitrequest_r;
	assign cpu_wait = cpu_wait_r;
	assign bus_own = bus_own_r;
	assign rd_strobe = rd_strobe_r;
	assign rd_addr = rd_addr_r;
	assign rd_io = rd_io_r;
	assign wr_strobe = wr_strobe_r;
	assign wr_addr = wr_addr_r;
	assign wr_io = wr_io_r;
	assign wr_data = wr_data_r;
	assign ch1_request = ch1_request_r;
	assign ch1_mem_to_io = ch1_mem_to_io_r;

	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_dst_step_inc: assert property (wr_done && dkind == KIND_INC && !(bus_wr && sel_dst)
		|=> dst_r == $past(dst_r) + 20'h1) else $error("dst not incremented");
	a_src_step_dec: assert property (rd_done && skind == KIND_DEC && !(bus_wr && sel_src)
		|=> src_r == $past(src_r) - 20'h1) else $error("src not decremented");
	a_reserved_idle: assert property (mode_bad |-> !rd_start)
		else $error("read started in reserved mode");
	a_mm_no_request: assert property (st_r == RD_IDLE && run && !io_mode && more
		&& buf_in_ready && !mode_bad |=> st_r == RD_READ)
		else $error("memory transfer waited for request");
	a_burst_hold: assert property (burst_hold && $past(burst_hold) |-> bus_own_r)
		else $error("bus dropped in burst");
	a_burst_no_steal: assert property (burst |-> st_r != RD_STEAL)
		else $error("steal cycle in burst");
	a_steal_release: assert property (st_r == RD_STEAL |-> !bus_own_r && !wr_strobe_r)
		else $error("bus kept in stolen cycle");
	a_io_paced: assert property (rd_start && io_mode |-> req0_ok)
		else $error("I/O read without request");
	a_read_wait: assert property (rd_start && rd_wait == 2'h3
		|=> rd_strobe_r [*4] ##1 !rd_strobe_r) else $error("read length wrong");
	a_edge_pend: assert property (dma_wait_ctrl_reg_r[DC_DMS0] && req0_edge |=> req0_pend_r)
		else $error("edge request lost");
	a_level_sense: assert property (!dma_wait_ctrl_reg_r[DC_DMS0] && io_mode && rd_start |-> req0_q2)
		else $error("level request not high");
	a_run_gate: assert property (!run |-> !rd_start)
		else $error("read without enables");
	a_count_dec: assert property (wr_done && !(bus_wr && sel_cnt)
		|=> cnt_r == $past(cnt_r) - CW'(1)) else $error("count not decremented");
	a_end_clear: assert property (last_byte && !sw_de0 |=> !de0_r)
		else $error("enable kept at zero count");
	a_ch1_dir: assert property (ch1_mem_to_io_r == !$past(dma_wait_ctrl_reg_r[DC_DIM_HI]))
		else $error("channel 1 direction wrong");

	c_burst_run: cover property (burst && wr_done ##1 wr_start);
	c_steal_cycle: cover property (st_r == RD_DRAIN ##[1:20] st_r == RD_STEAL);
	c_io_edge: cover property (io_mode && req0_pend_r && rd_start);
	c_buf_full: cover property (occ_r == 2'h2 && !wr_ready);
endmodule

// file: test/bus_far_side.sv
// Memory and I/O model on the far side of the byte mover
`timescale 1ns/10ps
module bus_far_side (
	input wire logic clock, // System clock
	input wire logic stall, // Throttle destination writes
	input wire logic rd_strobe, // Source access
	input wire logic [19:0] rd_addr, // Source address
	input wire logic rd_io, // Source in I/O space
	output logic [7:0] rd_data, // Source byte
	input wire logic wr_strobe, // Destination access
	input wire logic [19:0] wr_addr, // Destination address
	input wire logic [7:0] wr_data, // Destination byte
	input wire logic bus_own, // Mover owns the bus
	output logic wr_ready, // Destination can accept
	output int n_wr, // Writes seen
	output int n_rel, // Bus releases seen
	output logic saw_io, // An I/O source read was seen
	output logic [19:0] last_addr, // Last write address
	output logic [7:0] last_data // Last write byte
);
	logic [7:0] hold_r = 8'h00;
	logic [1:0] tick_r = 2'h0;
	logic wr_prev_r = 1'b0;
	logic own_prev_r = 1'b0;
	int n_wr_r = 0;
	int n_rel_r = 0;
	logic saw_io_r = 1'b0;
	// Released data line flips every cycle, so a late sample cannot match
	assign rd_data = rd_strobe ? (rd_addr[7:0] ^ 8'ha5) : ~hold_r;
	assign wr_ready = !(stall && tick_r != 2'h0);
	assign n_wr = n_wr_r;
	assign n_rel = n_rel_r;
	assign saw_io = saw_io_r;
	always @(posedge clock) begin
		tick_r <= tick_r + 2'h1;
		hold_r <= rd_data;
		wr_prev_r <= wr_strobe;
		own_prev_r <= bus_own;
		if (own_prev_r && !bus_own)
			n_rel_r <= n_rel_r + 1;
		if (rd_strobe && rd_io)
			saw_io_r <= 1'b1;
		if (wr_strobe && !wr_prev_r) begin
			n_wr_r <= n_wr_r + 1;
			last_addr <= wr_addr;
			last_data <= wr_data;
		end
	end
endmodule

// file: test/tb.sv
// Self-checking bench for the channel 0 mode control
`timescale 1ns/10ps
module tb;
	import dma_controller_pkg::*;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] address = 8'h00;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [31:0] readdata;
	logic waitrequest;
	logic request_in_0 = 1'b0;
	logic request_in_1 = 1'b0;
	logic nmi = 1'b0;
	logic cpu_cycle_start = 1'b0;
	logic cpu_cycle_io = 1'b0;
	logic cpu_wait, bus_own, rd_strobe, rd_io, wr_strobe, wr_io, wr_ready;
	logic [19:0] rd_addr, wr_addr, last_addr;
	logic [7:0] rd_data, wr_data, last_data;
	logic ch1_request, ch1_mem_to_io, saw_io;
	logic stall = 1'b0;
	logic wio_seen = 1'b0;
	int n_wr, n_rel, n_errors = 0, cmp_count = 0, tick = 0, w0, r0, ss, ds;
	int n_hi = 0;
	logic [7:0] modes [4] = '{8'h02, 8'h16, 8'h22, 8'h08};
	logic [31:0] q;

	always #20 clock = ~clock;

	dma_ch0_ctrl dma_ch0_ctrl_i (.clock(clock), .rst_n(rst_n), .address(address),
		.read(read), .write(write), .writedata(writedata), .byteenable(4'hf),
		.readdata(readdata), .waitrequest(waitrequest), .request_in_0(request_in_0),
		.request_in_1(request_in_1), .nmi(nmi), .cpu_cycle_start(cpu_cycle_start),
		.cpu_cycle_io(cpu_cycle_io), .cpu_wait(cpu_wait), .bus_own(bus_own),
		.rd_strobe(rd_strobe), .rd_addr(rd_addr), .rd_io(rd_io), .rd_data(rd_data),
		.wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_io(wr_io), .wr_data(wr_data),
		.wr_ready(wr_ready), .ch1_request(ch1_request), .ch1_mem_to_io(ch1_mem_to_io));

	bus_far_side bus_far_side_i (.clock(clock), .stall(stall), .rd_strobe(rd_strobe),
		.rd_addr(rd_addr), .rd_io(rd_io), .rd_data(rd_data), .wr_strobe(wr_strobe),
		.wr_addr(wr_addr), .wr_data(wr_data), .bus_own(bus_own), .wr_ready(wr_ready),
		.n_wr(n_wr), .n_rel(n_rel), .saw_io(saw_io), .last_addr(last_addr),
		.last_data(last_data));

	task automatic print_verdict();
		if (n_errors == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	always @(posedge clock) begin
		tick++;
		if (tick == 20000) begin
			n_errors++;
			print_verdict();
		end
	end

	always @(posedge clock) begin
		if (wr_strobe === 1'b1 && wr_io === 1'b1)
			wio_seen <= 1'b1;
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Request held until waitrequest is sampled low; data taken at that edge
	task automatic bus(input logic wr, input logic [5:0] idx, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge clock);
		address <= {idx, 2'b00};
		read <= !wr;
		write <= wr;
		writedata <= d;
		do begin
			@(posedge clock);
			t++;
		end while (waitrequest !== 1'b0 && t < 50);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		if (t >= 50)
			n_errors++;
	endtask

	task automatic wr(input logic [5:0] idx, input logic [31:0] d);
		bus(1'b1, idx, d);
	endtask

	task automatic rc(input logic [5:0] idx, input logic [31:0] exp);
		bus(1'b0, idx, 32'h0);
		chk($sformatf("register %h", idx), q, exp);
	endtask

	task automatic prep(input logic [7:0] mode, input logic [15:0] n);
		wr(IDX_SRC, 32'h100);
		wr(IDX_DST, 32'h200);
		wr(IDX_CNT, {16'h0, n});
		wr(IDX_MODE, {24'h0, mode});
		w0 = n_wr;
		r0 = n_rel;
		wr(IDX_EN, 32'h40);
	endtask

	// Poll until the channel enable drops at the end of the count
	task automatic finish_wait();
		int t;
		t = 0;
		do begin
			bus(1'b0, IDX_EN, 32'h0);
			t++;
		end while (q[EN_DE0] !== 1'b0 && t < 200);
	endtask

	task automatic wcount(input logic io, input int exp);
		int c;
		c = 0;
		@(posedge clock);
		cpu_cycle_start <= 1'b1;
		cpu_cycle_io <= io;
		@(posedge clock);
		cpu_cycle_start <= 1'b0;
		repeat (8) begin
			@(posedge clock);
			if (cpu_wait === 1'b1)
				c++;
		end
		chk("cpu_wait cycles", c, exp);
	endtask

	function automatic int stp(input logic [1:0] k);
		return (k == KIND_INC) ? 1 : (k == KIND_DEC) ? -1 : 0;
	endfunction

	initial begin
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		rc(IDX_MODE, 32'h0);
		rc(IDX_DMA_WAIT_CTRL_REG, 32'hf0);
		rc(IDX_EN, 32'h30);
		rc(6'h3f, 32'h0);
		wr(IDX_MODE, 32'hff);
		rc(IDX_MODE, 32'h3e);
		wcount(1'b0, 3);
		wr(IDX_DMA_WAIT_CTRL_REG, 32'h90);
		wcount(1'b0, 2);
		wcount(1'b1, 1);
		// Longest waits, so the mover runs with four-cycle accesses
		wr(IDX_DMA_WAIT_CTRL_REG, 32'hf0);
		for (int i = 0; i < 4; i++) begin
			stall <= (i == 0);
			prep(modes[i], 16'h3);
			finish_wait();
			ss = stp(modes[i][3:2]);
			ds = stp(modes[i][5:4]);
			rc(IDX_SRC, 32'h100 + ss * 3);
			rc(IDX_DST, 32'h200 + ds * 3);
			rc(IDX_CNT, 32'h0);
			chk("writes", n_wr - w0, 3);
			chk("last address", {12'h0, last_addr}, 32'h200 + ds * 2);
			chk("last byte", {24'h0, last_data}, ((32'h100 + ss * 2) & 8'hff) ^ 8'ha5);
			chk("bus releases", n_rel - r0, modes[i][1] ? 1 : 3);
		end
		stall <= 1'b0;
		prep(8'h2c, 16'h3);
		repeat (30) @(posedge clock);
		rc(IDX_CNT, 32'h3);
		rc(IDX_EN, 32'h71);
		nmi <= 1'b1;
		repeat (2) @(posedge clock);
		nmi <= 1'b0;
		repeat (4) @(posedge clock);
		rc(IDX_EN, 32'h70);
		wr(IDX_MODE, 32'h02);
		repeat (20) @(posedge clock);
		rc(IDX_CNT, 32'h3);
		wr(IDX_EN, 32'h0);
		wr(IDX_DMA_WAIT_CTRL_REG, 32'h00);
		prep(8'h0e, 16'h2);
		repeat (30) @(posedge clock);
		rc(IDX_CNT, 32'h2);
		request_in_0 <= 1'b1;
		finish_wait();
		request_in_0 <= 1'b0;
		rc(IDX_SRC, 32'h100);
		rc(IDX_DST, 32'h202);
		chk("io read", saw_io, 1'b1);
		// Edge sense on channel 0: a held-high request moves one byte per rise
		wr(IDX_DMA_WAIT_CTRL_REG, 32'h04);
		prep(8'h30, 16'h2);
		chk("io write", wio_seen, 1'b0);
		request_in_0 <= 1'b1;
		repeat (6) @(posedge clock);
		request_in_0 <= 1'b0;
		repeat (20) @(posedge clock);
		rc(IDX_CNT, 32'h1);
		request_in_0 <= 1'b1;
		finish_wait();
		request_in_0 <= 1'b0;
		rc(IDX_SRC, 32'h102);
		rc(IDX_DST, 32'h200);
		chk("io write", wio_seen, 1'b1);
		wr(IDX_DMA_WAIT_CTRL_REG, 32'h92);
		repeat (2) @(posedge clock);
		chk("ch1 direction", ch1_mem_to_io, 1'b0);
		request_in_1 <= 1'b1;
		repeat (5) @(posedge clock);
		chk("ch1 level", ch1_request, 1'b1);
		request_in_1 <= 1'b0;
		wr(IDX_DMA_WAIT_CTRL_REG, 32'h98);
		repeat (2) @(posedge clock);
		chk("ch1 direction", ch1_mem_to_io, 1'b1);
		request_in_1 <= 1'b1;
		repeat (8) begin
			@(posedge clock);
			if (ch1_request === 1'b1)
				n_hi++;
		end
		chk("ch1 edge", n_hi, 1);
		print_verdict();
	end
endmodule
